//--- hdl/pbc_pkg.sv
// pbc_pkg: constants and carrier types of the pll base clock selector
// assumes one 10 mhz control clock; crystal, vco and lock levels arrive as raw pins
package pbc_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ = 10_000_000;
    localparam logic [1:0] XFER_EDGES = 2'h3;

    // ---------------------------------------------------------------
    // field widths and reset values
    // ---------------------------------------------------------------
    localparam int MUL_W = 12;
    localparam int RDS_W = 4;
    localparam int VRS_W = 8;
    localparam int FB_W = 15;
    localparam logic [1:0] PRE_RST = 2'h0;
    localparam logic PLL_ON_RST = 1'b1;
    localparam logic SEL_RST = 1'b0;
    localparam logic [MUL_W-1:0] MUL_RST = 12'h002;
    localparam logic [RDS_W-1:0] RDS_RST = 4'h1;
    localparam logic [MUL_W-1:0] MUL_ONE = 12'h001;
    localparam logic [RDS_W-1:0] RDS_ONE = 4'h1;
    localparam logic [VRS_W-1:0] VRS_OFF = 8'h00;
    localparam logic [3:0] MUL_HI_MSB = 4'hB;

    // ---------------------------------------------------------------
    // carrier types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic lock_irq_enable;
        logic lock_change_flag;
        logic pll_power_on;
        logic base_clock_select;
        logic [1:0] prescale;
    } pbc_ctl_t;

    typedef struct packed {
        logic [FB_W-1:0] feedback_div;
        logic [3:0] prescale_factor;
        logic [MUL_W-1:0] mult_eff;
        logic [RDS_W-1:0] rdiv_eff;
    } pbc_divs_t;

    typedef enum logic [1:0] {
        PBC_RUN,
        PBC_HOLD
    } pbc_state_t;

endpackage : pbc_pkg

//--- hdl/pbc_pin_sync.sv
// pbc_pin_sync: two-flop synchroniser for one pin with edge pulses
// assumes the pin is unrelated to ref_clk_in; only the second stage and its delayed third-stage copy are looked at
`timescale 1ns/1ps
module pbc_pin_sync (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // pin and results
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out,
    output logic toggle_out
);
    logic meta_q, meta_d;
    logic stab_q, stab_d;
    logic last_q, last_d;

    always_comb begin
        meta_d = pin_in;
        stab_d = meta_q;
        last_d = stab_q;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            stab_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
            last_q <= last_d;
        end
    end

    assign level_out = stab_q;
    assign rise_out = stab_q & ~last_q;
    assign toggle_out = stab_q ^ last_q;
endmodule : pbc_pin_sync

//--- hdl/pbc_clock_selector.sv
// pbc_clock_selector: pll programming fields, interlocks, lock flag and base clock switch
// assumes source clocks well below 5 mhz after sampling, so edges are seen by ref_clk_in
`timescale 1ns/1ps

// Overview of operation
// - prescale exponent divides vco by two^P
// - feedback divisor N times two^P, reference R
// - zero R or N behaves as one
// - zero vco range disables pll, blocks selection
// - switching waits three edges of each source
// - selected source divided by two
// - select bit picks source, needs pll on
// - pll cannot turn off while selected
// - power and select need separate writes
// - usb clock follows selection, undivided
// - base clock has even duty cycle
// - interrupt comes from lock detector logic
// - buffered crystal copy driven out
// - crystal undivided, startup duty unknown tolerated
// - prescale field protected while pll on
// - lock toggle sets flag, read clears it
// - reset sets pll on, clears select
// - multiplier read-only while pll on
module pbc_clock_selector
    import pbc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // source pins
    input wire logic crystal_clock_in,
    input wire logic vco_clock_in,
    input wire logic lock_in,
    // system integration unit
    input wire logic oscillator_enable_in,
    // control register port
    input wire logic ctl_wr_in,
    input wire pbc_ctl_t ctl_wdata_in,
    input wire logic ctl_rd_in,
    output pbc_ctl_t ctl_rdata_out,
    // programming ports
    input wire logic mul_lo_wr_in,
    input wire logic mul_hi_wr_in,
    input wire logic [7:0] mul_wdata_in,
    input wire logic rdiv_wr_in,
    input wire logic [RDS_W-1:0] rdiv_wdata_in,
    input wire logic [VRS_W-1:0] vco_range_in,
    input wire logic auto_bw_in,
    output logic [MUL_W-1:0] mul_out,
    output logic [RDS_W-1:0] rdiv_out,
    output pbc_divs_t divs_out,
    // clocks and status out
    output logic base_clock_out,
    output logic usb_ref_clock_out,
    output logic buffered_crystal_out,
    output logic osc_enable_out,
    output logic pll_enable_out,
    output logic switching_out,
    output logic lock_change_irq_out
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic xtal_lvl, xtal_rise, vco_lvl, vco_rise, lock_tgl;

    pbc_pin_sync u_xtal (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pin_in(crystal_clock_in),
        .level_out(xtal_lvl),
        .rise_out(xtal_rise),
        .toggle_out()
    );

    pbc_pin_sync u_vco (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pin_in(vco_clock_in),
        .level_out(vco_lvl),
        .rise_out(vco_rise),
        .toggle_out()
    );

    pbc_pin_sync u_lock (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pin_in(lock_in),
        .level_out(),
        .rise_out(),
        .toggle_out(lock_tgl)
    );

    // ---------------------------------------------------------------
    // control fields
    // ---------------------------------------------------------------
    logic pll_on_q, pll_on_d;
    logic sel_q, sel_d;
    logic irq_en_q, irq_en_d;
    logic flag_q, flag_d;
    logic [1:0] pre_q, pre_d;
    logic [MUL_W-1:0] mul_q, mul_d;
    logic [RDS_W-1:0] rds_q, rds_d;
    logic range_ok;

    assign range_ok = (vco_range_in != VRS_OFF);

    always_comb begin
        pll_on_d = pll_on_q;
        sel_d = sel_q;
        irq_en_d = irq_en_q;
        pre_d = pre_q;
        mul_d = mul_q;
        rds_d = rds_q;
        if (ctl_wr_in) begin
            // interlocks look at the old values, so one write can't do both steps
            if (!sel_q) begin
                pll_on_d = ctl_wdata_in.pll_power_on;
            end
            if (pll_on_q && range_ok && (sel_q || ctl_wdata_in.pll_power_on)) begin
                sel_d = ctl_wdata_in.base_clock_select;
            end
            if (!pll_on_q) begin
                pre_d = ctl_wdata_in.prescale;
            end
            irq_en_d = ctl_wdata_in.lock_irq_enable;
        end
        if (!auto_bw_in) begin
            irq_en_d = 1'b0;
        end
        if (!pll_on_q || !range_ok) begin
            sel_d = 1'b0;
        end
        if (!pll_on_q) begin
            if (mul_lo_wr_in) begin
                mul_d[7:0] = mul_wdata_in;
            end
            if (mul_hi_wr_in) begin
                mul_d[MUL_W-1:8] = mul_wdata_in[MUL_HI_MSB-4'h8:0];
            end
        end
        if (rdiv_wr_in) begin
            rds_d = rdiv_wdata_in;
        end
        // a toggle in the clearing cycle still leaves the flag set
        flag_d = flag_q;
        if (ctl_rd_in) begin
            flag_d = 1'b0;
        end
        if (lock_tgl) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pll_on_q <= PLL_ON_RST;
            sel_q <= SEL_RST;
            irq_en_q <= 1'b0;
            flag_q <= 1'b0;
            pre_q <= PRE_RST;
            mul_q <= MUL_RST;
            rds_q <= RDS_RST;
        end else begin
            pll_on_q <= pll_on_d;
            sel_q <= sel_d;
            irq_en_q <= irq_en_d;
            flag_q <= flag_d;
            pre_q <= pre_d;
            mul_q <= mul_d;
            rds_q <= rds_d;
        end
    end

    // ---------------------------------------------------------------
    // effective divisors
    // ---------------------------------------------------------------
    logic [MUL_W-1:0] mul_eff;
    logic [RDS_W-1:0] rds_eff;

    always_comb begin
        mul_eff = (mul_q == '0) ? MUL_ONE : mul_q;
        rds_eff = (rds_q == '0) ? RDS_ONE : rds_q;
        divs_out.mult_eff = mul_eff;
        divs_out.rdiv_eff = rds_eff;
        divs_out.prescale_factor = 4'h1 << pre_q;
        divs_out.feedback_div = FB_W'({3'h0, mul_eff} << pre_q);
    end

    assign mul_out = mul_q;
    assign rdiv_out = rds_q;

    // ---------------------------------------------------------------
    // source switch and divider
    // ---------------------------------------------------------------
    pbc_state_t state_q, state_d;
    logic act_q, act_d;
    logic [1:0] xcnt_q, xcnt_d, vcnt_q, vcnt_d;
    logic base_q, base_d;
    logic usb_q, usb_d;
    logic bufx_q, bufx_d;
    logic src_rise;

    assign src_rise = act_q ? vco_rise : xtal_rise;

    always_comb begin
        state_d = state_q;
        act_d = act_q;
        xcnt_d = xcnt_q;
        vcnt_d = vcnt_q;
        base_d = base_q;
        usb_d = act_q ? vco_lvl : xtal_lvl;
        bufx_d = xtal_lvl;
        case (state_q)
            PBC_RUN: begin
                if (src_rise) begin
                    base_d = ~base_q;
                end
                if (sel_q != act_q) begin
                    state_d = PBC_HOLD;
                    xcnt_d = '0;
                    vcnt_d = '0;
                end
            end
            PBC_HOLD: begin
                // output frozen; usb clock too, so neither sees a runt pulse
                usb_d = usb_q;
                if (xtal_rise && xcnt_q != XFER_EDGES) begin
                    xcnt_d = xcnt_q + 2'h1;
                end
                if (vco_rise && vcnt_q != XFER_EDGES) begin
                    vcnt_d = vcnt_q + 2'h1;
                end
                if (xcnt_q == XFER_EDGES && vcnt_q == XFER_EDGES) begin
                    act_d = sel_q;
                    state_d = PBC_RUN;
                end
            end
            default: state_d = PBC_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= PBC_RUN;
            act_q <= SEL_RST;
            xcnt_q <= '0;
            vcnt_q <= '0;
            base_q <= 1'b0;
            usb_q <= 1'b0;
            bufx_q <= 1'b0;
        end else begin
            state_q <= state_d;
            act_q <= act_d;
            xcnt_q <= xcnt_d;
            vcnt_q <= vcnt_d;
            base_q <= base_d;
            usb_q <= usb_d;
            bufx_q <= bufx_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign base_clock_out = base_q;
    assign usb_ref_clock_out = usb_q;
    assign buffered_crystal_out = bufx_q;
    assign switching_out = (state_q == PBC_HOLD);
    assign osc_enable_out = oscillator_enable_in;
    assign pll_enable_out = oscillator_enable_in & pll_on_q & range_ok;
    assign lock_change_irq_out = flag_q & irq_en_q & auto_bw_in;

    always_comb begin
        ctl_rdata_out.lock_irq_enable = irq_en_q;
        ctl_rdata_out.lock_change_flag = flag_q & auto_bw_in;
        ctl_rdata_out.pll_power_on = pll_on_q;
        ctl_rdata_out.base_clock_select = sel_q;
        ctl_rdata_out.prescale = pre_q;
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_pre_locked;
        pll_on_q |=> $stable(pre_q);
    endproperty
    a_pre_locked: assert property (p_pre_locked) else $error("prescale changed with pll on");

    property p_mul_locked;
        pll_on_q |=> $stable(mul_q);
    endproperty
    a_mul_locked: assert property (p_mul_locked) else $error("multiplier changed with pll on");

    property p_sel_needs_pll;
        sel_q |-> pll_on_q && $past(range_ok);
    endproperty
    a_sel_needs_pll: assert property (p_sel_needs_pll) else $error("select without pll");

    property p_no_off_when_sel;
        sel_q && ctl_wr_in && !ctl_wdata_in.pll_power_on |=> pll_on_q;
    endproperty
    a_no_off_when_sel: assert property (p_no_off_when_sel) else $error("pll turned off");

    property p_one_step;
        !pll_on_q && ctl_wr_in |=> !sel_q;
    endproperty
    a_one_step: assert property (p_one_step) else $error("select with power in one write");

    property p_no_both;
        ctl_wr_in && pll_on_q && !sel_q && !ctl_wdata_in.pll_power_on |=> !sel_q;
    endproperty
    a_no_both: assert property (p_no_both) else $error("select with pll off");

    property p_flag_sets;
        lock_tgl |=> flag_q;
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("lock toggle lost");

    property p_irq;
        flag_q && irq_en_q && auto_bw_in |-> lock_change_irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_hold_static;
        state_q == PBC_HOLD |=> $stable(base_q) || $past(state_q) != PBC_HOLD;
    endproperty
    a_hold_static: assert property (p_hold_static) else $error("base clock moved in switch");

    property p_div_two;
        state_q == PBC_RUN && src_rise |=> base_q != $past(base_q);
    endproperty
    a_div_two: assert property (p_div_two) else $error("divider missed edge");

    property p_zero_one;
        rds_q == '0 |-> divs_out.rdiv_eff == RDS_ONE;
    endproperty
    a_zero_one: assert property (p_zero_one) else $error("zero divider not one");

endmodule : pbc_clock_selector

//--- sim/pbc_sim_model.sv
// pbc_sim_model: integration unit side, source clocks and oscillator enable
// assumes the bench reads only the levels; periods are in ns
`timescale 1ns/1ps
module pbc_sim_model #(
    parameter int XP = 1000,
    parameter int VP = 600
) (
    // source clocks and enable
    output logic crystal_clock_out,
    output logic vco_clock_out,
    output logic oscillator_enable_out
);
    // ------------------------------------------------------------
    // enable and clocks
    // ------------------------------------------------------------
    initial begin
        oscillator_enable_out = 1'b0;
        #260 oscillator_enable_out = 1'b1;
    end
    // sources stand low while the oscillator is disabled
    initial begin
        crystal_clock_out = 1'b0;
        #37;
        forever #(XP / 2) crystal_clock_out = oscillator_enable_out & ~crystal_clock_out;
    end
    initial begin
        vco_clock_out = 1'b0;
        #81;
        forever #(VP / 2) vco_clock_out = oscillator_enable_out & ~vco_clock_out;
    end
endmodule : pbc_sim_model

//--- sim/pbc_clock_selector_bench.sv
// pbc_clock_selector_bench: directed checks of fields, interlocks, switch and flag
// assumes pbc_sim_model supplies the source clocks; periods judged within 150 ns
`timescale 1ns/1ps
module pbc_clock_selector_bench;
    import pbc_pkg::*;
    localparam int XP = 1000;
    localparam int VP = 600;
    logic ref_clk_in, rst_in, xc, vc, osc_en, lock_in, ctl_wr_in, ctl_rd_in;
    logic mul_lo_wr_in, mul_hi_wr_in, rdiv_wr_in, auto_bw_in;
    logic base_clock_out, usb_ref_clock_out, buffered_crystal_out;
    logic osc_enable_out, pll_enable_out, switching_out, lock_change_irq_out;
    logic [7:0] mul_wdata_in, vco_range_in;
    logic [RDS_W-1:0] rdiv_wdata_in, rdiv_out;
    logic [MUL_W-1:0] mul_out;
    pbc_ctl_t ctl_wdata_in, ctl_rdata_out;
    pbc_divs_t divs_out;
    int failures = 0, comparisons = 0, cycles = 0;
    realtime bt = 0, bp = 0, ut = 0, up = 0, ct = 0, cp = 0;
    logic sw_prev = 0, sw_seen = 0, base_prev = 0;

    pbc_sim_model #(.XP(XP), .VP(VP)) sim_unit (.crystal_clock_out(xc),
        .vco_clock_out(vc), .oscillator_enable_out(osc_en));
    pbc_clock_selector dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .crystal_clock_in(xc), .vco_clock_in(vc), .lock_in(lock_in),
        .oscillator_enable_in(osc_en), .ctl_wr_in(ctl_wr_in), .ctl_wdata_in(ctl_wdata_in),
        .ctl_rd_in(ctl_rd_in), .ctl_rdata_out(ctl_rdata_out), .mul_lo_wr_in(mul_lo_wr_in),
        .mul_hi_wr_in(mul_hi_wr_in), .mul_wdata_in(mul_wdata_in), .rdiv_wr_in(rdiv_wr_in),
        .rdiv_wdata_in(rdiv_wdata_in), .vco_range_in(vco_range_in), .auto_bw_in(auto_bw_in),
        .mul_out(mul_out), .rdiv_out(rdiv_out), .divs_out(divs_out),
        .base_clock_out(base_clock_out), .usb_ref_clock_out(usb_ref_clock_out),
        .buffered_crystal_out(buffered_crystal_out), .osc_enable_out(osc_enable_out),
        .pll_enable_out(pll_enable_out), .switching_out(switching_out),
        .lock_change_irq_out(lock_change_irq_out));

    // ------------------------------------------------------------
    // clock, timeout and period monitors
    // ------------------------------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end
    always @(posedge base_clock_out) begin bp = $realtime - bt; bt = $realtime; end
    always @(posedge usb_ref_clock_out) begin up = $realtime - ut; ut = $realtime; end
    always @(posedge buffered_crystal_out) begin cp = $realtime - ct; ct = $realtime; end
    // base clock must stand still for the whole switch
    always @(negedge ref_clk_in) begin
        if (switching_out === 1'b1 && sw_prev) begin
            chk("base_hold", base_clock_out, base_prev);
        end
        sw_prev = (switching_out === 1'b1);
        sw_seen = sw_seen | sw_prev;
        base_prev = base_clock_out;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic near(input string n, input realtime seen, input realtime exp);
        chk(n, 32'(seen > exp - 150.0 && seen < exp + 150.0), 32'h1);
    endtask : near
    task automatic tick();
        @(posedge ref_clk_in);
        #10;
    endtask : tick
    task automatic wr_ctl(input logic ie, input logic on, input logic sel, input logic [1:0] pre);
        ctl_wdata_in = '{ie, 1'b0, on, sel, pre};
        ctl_wr_in = 1'b1;
        tick();
        ctl_wr_in = 1'b0;
        tick();
    endtask : wr_ctl
    task automatic wr_mul(input logic [11:0] v);
        mul_wdata_in = v[7:0];
        mul_lo_wr_in = 1'b1;
        tick();
        mul_lo_wr_in = 1'b0;
        mul_hi_wr_in = 1'b1;
        mul_wdata_in = {4'hF, v[11:8]};
        tick();
        mul_hi_wr_in = 1'b0;
        tick();
    endtask : wr_mul
    task automatic wr_rdiv(input logic [3:0] v);
        rdiv_wdata_in = v;
        rdiv_wr_in = 1'b1;
        tick();
        rdiv_wr_in = 1'b0;
        tick();
    endtask : wr_rdiv
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_in, lock_in, ctl_wr_in, ctl_rd_in, mul_lo_wr_in, mul_hi_wr_in} = 6'h20;
        {rdiv_wr_in, auto_bw_in, mul_wdata_in, rdiv_wdata_in} = 14'h1000;
        ctl_wdata_in = '0;
        vco_range_in = 8'h01;
        repeat (4) tick();
        rst_in = 1'b0;
        tick();
        chk("ctl_reset", ctl_rdata_out, 6'h08);
        chk("mul_reset", mul_out, 12'h002);
        chk("osc_en", osc_enable_out, 1'b1);
        wr_ctl(0, 1, 0, 2'h3);
        chk("pre_locked", ctl_rdata_out, 6'h08);
        wr_mul(12'h345);
        chk("mul_locked", mul_out, 12'h002);
        wr_ctl(0, 0, 1, 2'h0);
        chk("pll_off", {ctl_rdata_out, pll_enable_out}, 7'h00);
        wr_mul(12'h004);
        wr_rdiv(4'h0);
        for (int p = 0; p < 4; p++) begin
            wr_ctl(0, 0, 0, p[1:0]);
            chk("pre_factor", divs_out.prescale_factor, 32'h1 << p);
            chk("fb_div", divs_out.feedback_div, 32'h4 << p);
        end
        chk("rdiv_zero", {rdiv_out, divs_out.rdiv_eff}, 8'h01);
        wr_mul(12'h000);
        chk("mul_zero", {mul_out, divs_out.mult_eff}, 24'h000001);
        wr_mul(12'hA04);
        chk("mul_hi", mul_out, 12'hA04);
        wr_mul(12'h004);
        wr_ctl(0, 0, 1, 2'h0);
        chk("sel_off", ctl_rdata_out, 6'h00);
        wr_ctl(0, 1, 1, 2'h0);
        chk("one_write", {ctl_rdata_out, pll_enable_out}, 7'h11);
        vco_range_in = 8'h00;
        wr_ctl(0, 1, 1, 2'h0);
        chk("range_zero", {ctl_rdata_out, pll_enable_out}, 7'h10);
        vco_range_in = 8'h01;
        repeat (60) tick();
        near("base_xtal", bp, 2 * XP);
        near("usb_xtal", up, XP);
        near("buf_xtal", cp, XP);
        wr_ctl(0, 1, 1, 2'h0);
        chk("sel_on", ctl_rdata_out, 6'h0C);
        for (int i = 0; i < 200 && !(sw_seen && switching_out === 1'b0); i++) tick();
        chk("switched", {sw_seen, switching_out}, 2'b10);
        repeat (60) tick();
        near("base_vco", bp, 2 * VP);
        near("usb_vco", up, VP);
        wr_ctl(0, 0, 1, 2'h0);
        chk("off_refused", ctl_rdata_out, 6'h0C);
        wr_ctl(0, 0, 0, 2'h0);
        chk("desel_only", ctl_rdata_out, 6'h08);
        auto_bw_in = 1'b0;
        wr_ctl(1, 1, 0, 2'h0);
        chk("ie_forced", ctl_rdata_out, 6'h08);
        auto_bw_in = 1'b1;
        wr_ctl(1, 1, 0, 2'h0);
        lock_in = 1'b1;
        repeat (5) tick();
        chk("flag_set", {ctl_rdata_out, lock_change_irq_out}, 7'h71);
        ctl_rd_in = 1'b1;
        tick();
        ctl_rd_in = 1'b0;
        tick();
        chk("flag_clr", {ctl_rdata_out, lock_change_irq_out}, 7'h50);
        // pll off with the prescale write refused, then a reset in mid-run
        wr_ctl(1, 0, 0, 2'h2);
        chk("pre_kept", ctl_rdata_out, 6'h20);
        {rst_in, lock_in} = 2'b10;
        repeat (4) tick();
        rst_in = 1'b0;
        tick();
        chk("ctl_rerun", ctl_rdata_out, 6'h08);
        chk("mul_rerun", mul_out, 12'h002);
        wrap_up();
    end
endmodule : pbc_clock_selector_bench
